// ===== shared/lwt_pkg.sv
package lwt_pkg;

  // ----------------------------------------------------------------
  // bus shape
  // ----------------------------------------------------------------
  localparam int          ADDR_W         = 8;
  localparam int          DATA_W         = 16;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0]  OFF_LOAD       = 8'h00;
  localparam logic [7:0]  OFF_COUNT      = 8'h04;
  localparam logic [7:0]  OFF_CTRL       = 8'h08;
  localparam logic [7:0]  OFF_KEY        = 8'h0c;
  localparam logic [7:0]  OFF_STATUS     = 8'h18;

  // ----------------------------------------------------------------
  // reset values and fixed numbers
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_LOAD       = 16'h0400;
  localparam logic [15:0] RST_COUNT      = 16'h1000;
  localparam logic [15:0] RST_CTRL       = 16'h00e9;
  localparam logic [15:0] RST_STATUS     = 16'h0020;
  localparam logic [15:0] FIXED_RELOAD   = 16'h1000;
  localparam logic [15:0] SERVICE_KEY    = 16'hcccc;
  localparam logic [15:0] MIN_LOAD_DIV1  = 16'h0003;

  // ----------------------------------------------------------------
  // control and status fields
  // ----------------------------------------------------------------
  localparam int          CTRL_FREEZE    = 0;
  localparam int          CTRL_IRQ_MODE  = 1;
  localparam int          CTRL_PRE_LSB   = 2;
  localparam int          CTRL_ENABLE    = 5;
  localparam int          CTRL_MODE      = 6;
  localparam logic [15:0] CTRL_KEEP_MASK = 16'h006f;
  localparam logic [15:0] CTRL_SET_MASK  = 16'h0080;
  localparam int          STA_IRQ        = 0;
  localparam int          STA_KEY_PEND   = 1;
  localparam int          STA_LOAD_PEND  = 2;
  localparam int          STA_CTRL_PEND  = 3;
  localparam int          STA_LOCK       = 4;

  // ----------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------
  localparam int          PRE_CNT_W      = 12;
  localparam logic [1:0]  PRE_DIV1       = 2'h0;
  localparam logic [1:0]  PRE_DIV16      = 2'h1;
  localparam logic [1:0]  PRE_DIV256     = 2'h2;
  localparam logic [1:0]  PRE_DIV4096    = 2'h3;
  localparam logic [11:0] PRE_LIM_DIV1   = 12'h000;
  localparam logic [11:0] PRE_LIM_DIV16  = 12'h00f;
  localparam logic [11:0] PRE_LIM_DIV256 = 12'h0ff;
  localparam logic [11:0] PRE_LIM_DIV4096 = 12'hfff;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS  = 50;
  localparam int          LF_FREQ_HZ     = 32768;
  localparam int          KEY_GAP_NS     = 125000;
  localparam int          KEY_GAP_CYC    = (KEY_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  function automatic logic [15:0] lwt_reload(input logic periodic, input logic [15:0] load);
    lwt_reload = periodic ? load : FIXED_RELOAD;
  endfunction

endpackage

// ===== shared/lwt_bus_if.sv
interface lwt_bus_if;
  logic                       req;
  logic                       we;
  logic [lwt_pkg::ADDR_W-1:0] addr;
  logic [lwt_pkg::DATA_W-1:0] wdata;
  logic                       ack;
  logic [lwt_pkg::DATA_W-1:0] rdata;

  modport dev
  (
    input  req,
    input  we,
    input  addr,
    input  wdata,
    output ack,
    output rdata
  );

  modport host
  (
    output req,
    output we,
    output addr,
    output wdata,
    input  ack,
    input  rdata
  );
endinterface

// ===== hw/lwt_prescaler.sv
module lwt_prescaler #(
  parameter int CNT_W = lwt_pkg::PRE_CNT_W
)
(
  input  wire logic       clock,
  input  wire logic       arst_n,
  input  wire logic       tick,
  input  wire logic       restart,
  input  wire logic [1:0] sel,
  output wire logic       tc
);
  import lwt_pkg::*;

  generate
    if (CNT_W < PRE_CNT_W)
    begin : g_chk
      $error("prescaler counter too narrow for divide by 4096");
    end
  endgenerate

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [11:0]      limit;
  logic             at_limit;

  // divide ratio select
  assign limit    = (sel == PRE_DIV1)   ? PRE_LIM_DIV1 :
                    (sel == PRE_DIV16)  ? PRE_LIM_DIV16 :
                    (sel == PRE_DIV256) ? PRE_LIM_DIV256 : PRE_LIM_DIV4096;
  assign at_limit = (cnt_r == CNT_W'(limit));
  assign tc       = tick & at_limit & ~restart;
  assign cnt_nxt  = restart ? '0 :
                    ~tick ? cnt_r :
                    at_limit ? '0 : cnt_r + CNT_W'(1);

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      cnt_r <= '0;
    else
      cnt_r <= cnt_nxt;
  end

endmodule

// ===== hw/lwt_device.sv
// Behaviour
// - 16-bit down counter, prescaler 1/16/256/4096
// - counter steps only on low-frequency oscillator edges
// - control bit 1 picks reset or interrupt
// - timeout after ratio times load plus one
// - enable write locks control and load
// - clearing enable resets and stops counter
// - fixed mode counts from 0x1000, ignores load
// - setting enable restarts from mode's reload value
// - periodic load write goes straight to counter
// - key write reloads counter, new period
// - wrong key fires the timeout action
// - key write clears pending interrupt
// - software spaces key writes four slow cycles
// - decrement per tick, wrap at zero times out
// - freeze bit holds count while cpu halted
// - freeze bit written with the enabling write
// - prescaler field bits 3:2 decoding
// - divide-by-one needs load above 0x2
// - reserved control bits written as fixed
// - live count readable, resets to 0x1000
// - status bit 3 shows control write pending
module lwt_device
(
  lwt_bus_if.dev    bus,
  input  wire logic clock,
  input  wire logic arst_n,
  input  wire logic low_freq_oscillator,
  input  wire logic cpu_halted,
  output logic      wdog_reset,
  output logic      wdog_irq
);
  import lwt_pkg::*;

  // ----------------------------------------------------------------
  // slow oscillator sampling
  // ----------------------------------------------------------------
  logic lf_s1_r;
  logic lf_s2_r;
  logic lf_s3_r;
  logic lf_lvl_r;
  logic lf_agree;
  logic lf_tick;

  assign lf_agree = (lf_s2_r == lf_s3_r);
  assign lf_tick  = lf_agree & lf_s3_r & ~lf_lvl_r;

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lf_s1_r  <= 1'b0;
      lf_s2_r  <= 1'b0;
      lf_s3_r  <= 1'b0;
      lf_lvl_r <= 1'b0;
    end
    else
    begin
      lf_s1_r  <= low_freq_oscillator;
      lf_s2_r  <= lf_s1_r;
      lf_s3_r  <= lf_s2_r;
      lf_lvl_r <= lf_agree ? lf_s3_r : lf_lvl_r;
    end
  end

  // ----------------------------------------------------------------
  // register bus decode
  // ----------------------------------------------------------------
  logic        ack_r;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic [15:0] load_r;
  logic [15:0] load_nxt;
  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic [15:0] ctrl_r;
  logic [15:0] ctrl_nxt;
  logic [15:0] status_rd;
  logic        lock_r;
  logic        disabled_once_r;
  logic        irq_r;
  logic        irq_nxt;
  logic        reset_r;
  logic        reset_nxt;
  logic        pend_ctrl_r;
  logic        pend_load_r;
  logic        pend_key_r;

  logic        take;
  logic        wr;
  logic        wr_load;
  logic        wr_ctrl;
  logic        wr_key;
  logic        ctrl_ok;
  logic        load_ok;
  logic        en_set;
  logic        en_clr;
  logic        key_good;
  logic        key_bad;

  assign take     = bus.req & ~ack_r;
  assign wr       = take & bus.we;
  assign wr_load  = wr & (bus.addr == OFF_LOAD);
  assign wr_ctrl  = wr & (bus.addr == OFF_CTRL);
  assign wr_key   = wr & (bus.addr == OFF_KEY);
  // only one disable is honoured, and nothing once locked
  assign ctrl_ok  = wr_ctrl & ~lock_r & ~(~bus.wdata[CTRL_ENABLE] & disabled_once_r);
  assign load_ok  = wr_load & ~lock_r;
  assign en_set   = ctrl_ok & bus.wdata[CTRL_ENABLE];
  assign en_clr   = ctrl_ok & ~bus.wdata[CTRL_ENABLE];
  assign key_good = wr_key & (bus.wdata == SERVICE_KEY);
  assign key_bad  = wr_key & (bus.wdata != SERVICE_KEY);

  // ----------------------------------------------------------------
  // count engine
  // ----------------------------------------------------------------
  logic        enabled;
  logic        periodic;
  logic        frozen;
  logic        pre_tc;
  logic        pre_restart;
  logic        step;
  logic        timeout_evt;
  logic        fire;
  logic [15:0] reload_now;

  assign enabled     = ctrl_r[CTRL_ENABLE];
  assign periodic    = ctrl_r[CTRL_MODE];
  assign frozen      = ctrl_r[CTRL_FREEZE] & cpu_halted;
  assign step        = enabled & ~frozen & pre_tc;
  // timeout taken on the wrap tick, giving ratio * (load + 1) slow cycles
  assign timeout_evt = step & (count_r == 16'h0000);
  assign fire        = timeout_evt | key_bad;
  assign reload_now  = lwt_reload(periodic, load_r);
  assign pre_restart = en_set | en_clr | key_good | (load_ok & periodic);

  lwt_prescaler #(
    .CNT_W   (PRE_CNT_W)
  ) u_pre (
    .clock   (clock),
    .arst_n  (arst_n),
    .tick    (lf_tick),
    .restart (pre_restart),
    .sel     (ctrl_r[CTRL_PRE_LSB +: 2]),
    .tc      (pre_tc)
  );

  assign count_nxt = en_clr ? RST_COUNT :
                     en_set ? lwt_reload(bus.wdata[CTRL_MODE], load_r) :
                     key_good ? reload_now :
                     (load_ok & periodic) ? bus.wdata :
                     ~step ? count_r :
                     (count_r == 16'h0000) ? reload_now : count_r - 16'h0001;

  assign ctrl_nxt  = ctrl_ok ? bus.wdata : ctrl_r;
  assign load_nxt  = load_ok ? bus.wdata : load_r;

  // the key's prescaler restart blocks any timeout in the clearing cycle, so the request always drops
  assign irq_nxt   = (fire & ctrl_r[CTRL_IRQ_MODE]) | (irq_r & ~key_good);
  assign reset_nxt = fire & ~ctrl_r[CTRL_IRQ_MODE];

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      count_r <= RST_COUNT;
      ctrl_r  <= RST_CTRL;
      load_r  <= RST_LOAD;
      irq_r   <= 1'b0;
      reset_r <= 1'b0;
    end
    else
    begin
      count_r <= count_nxt;
      ctrl_r  <= ctrl_nxt;
      load_r  <= load_nxt;
      irq_r   <= irq_nxt;
      reset_r <= reset_nxt;
    end
  end

  // ----------------------------------------------------------------
  // lock and write tracking
  // ----------------------------------------------------------------
  // pending flags drop at the next slow edge; a new write wins
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lock_r          <= 1'b0;
      disabled_once_r <= 1'b0;
      pend_ctrl_r     <= 1'b0;
      pend_load_r     <= 1'b0;
      pend_key_r      <= 1'b0;
    end
    else
    begin
      lock_r          <= lock_r | en_set;
      disabled_once_r <= disabled_once_r | en_clr;
      pend_ctrl_r     <= ctrl_ok | (pend_ctrl_r & ~lf_tick);
      pend_load_r     <= load_ok | (pend_load_r & ~lf_tick);
      pend_key_r      <= wr_key | (pend_key_r & ~lf_tick);
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb
  begin
    status_rd                = RST_STATUS;
    status_rd[STA_IRQ]       = irq_r;
    status_rd[STA_KEY_PEND]  = pend_key_r;
    status_rd[STA_LOAD_PEND] = pend_load_r;
    status_rd[STA_CTRL_PEND] = pend_ctrl_r;
    status_rd[STA_LOCK]      = lock_r;
  end

  // key register and unmapped offsets read zero
  assign rdata_nxt = ~(take & ~bus.we) ? rdata_r :
                     (bus.addr == OFF_LOAD)   ? load_r :
                     (bus.addr == OFF_COUNT)  ? count_r :
                     (bus.addr == OFF_CTRL)   ? ctrl_r :
                     (bus.addr == OFF_STATUS) ? status_rd : 16'h0000;

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ack_r   <= 1'b0;
      rdata_r <= 16'h0000;
    end
    else
    begin
      ack_r   <= take;
      rdata_r <= rdata_nxt;
    end
  end

  assign bus.ack    = ack_r;
  assign bus.rdata  = rdata_r;
  assign wdog_reset = reset_r;
  assign wdog_irq   = irq_r;

endmodule

// ===== hw/lwt_host.sv
module lwt_host #(
  parameter int GAP_CYCLES = lwt_pkg::KEY_GAP_CYC
)
(
  lwt_bus_if.host                    bus,
  input  wire logic                  clock,
  input  wire logic                  arst_n,
  input  wire logic                  cmd_valid,
  input  wire logic                  cmd_write,
  input  wire logic [7:0]            cmd_addr,
  input  wire logic [15:0]           cmd_wdata,
  output logic                       cmd_ready,
  output logic                       rsp_valid,
  output logic [15:0]                rsp_rdata
);
  import lwt_pkg::*;

  localparam int GAP_W = $clog2(GAP_CYCLES + 1);

  generate
    if (GAP_CYCLES < 1)
    begin : g_chk
      $error("key write gap must be at least one cycle");
    end
  endgenerate

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_BUS  = 3'b010,
    ST_GAP  = 3'b100
  } lwt_host_state_e;

  lwt_host_state_e state_r;
  logic            req_r;
  logic            we_r;
  logic [7:0]      addr_r;
  logic [15:0]     wdata_r;
  logic            ready_r;
  logic            rsp_valid_r;
  logic [15:0]     rsp_rdata_r;
  logic [1:0]      pre_shadow_r;
  logic [GAP_W-1:0] gap_r;

  logic            accept;
  logic            is_ctrl;
  logic            is_load;
  logic            is_key;
  logic            gap_done;
  logic [15:0]     ctrl_shaped;
  logic [15:0]     load_shaped;
  logic [15:0]     wdata_shaped;

  assign accept       = cmd_valid & ready_r;
  assign is_ctrl      = cmd_write & (cmd_addr == OFF_CTRL);
  assign is_load      = cmd_write & (cmd_addr == OFF_LOAD);
  assign is_key       = we_r & (addr_r == OFF_KEY);
  assign gap_done     = (gap_r == GAP_W'(1));
  // freeze and enable bits pass together as given
  assign ctrl_shaped  = (cmd_wdata & CTRL_KEEP_MASK) | CTRL_SET_MASK;
  assign load_shaped  = ((pre_shadow_r == PRE_DIV1) && (cmd_wdata < MIN_LOAD_DIV1)) ?
                        MIN_LOAD_DIV1 : cmd_wdata;
  assign wdata_shaped = is_ctrl ? ctrl_shaped : is_load ? load_shaped : cmd_wdata;

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_r      <= ST_IDLE;
      req_r        <= 1'b0;
      we_r         <= 1'b0;
      addr_r       <= 8'h00;
      wdata_r      <= 16'h0000;
      ready_r      <= 1'b0;
      rsp_valid_r  <= 1'b0;
      rsp_rdata_r  <= 16'h0000;
      pre_shadow_r <= RST_CTRL[CTRL_PRE_LSB +: 2];
      gap_r        <= '0;
    end
    else
    begin
      rsp_valid_r <= 1'b0;
      case (state_r)
        ST_IDLE:
        begin
          ready_r <= 1'b1;
          if (accept)
          begin
            ready_r      <= 1'b0;
            req_r        <= 1'b1;
            we_r         <= cmd_write;
            addr_r       <= cmd_addr;
            wdata_r      <= wdata_shaped;
            pre_shadow_r <= is_ctrl ? cmd_wdata[CTRL_PRE_LSB +: 2] : pre_shadow_r;
            state_r      <= ST_BUS;
          end
        end
        ST_BUS:
        begin
          if (bus.ack)
          begin
            req_r       <= 1'b0;
            rsp_valid_r <= 1'b1;
            rsp_rdata_r <= we_r ? 16'h0000 : bus.rdata;
            gap_r       <= GAP_W'(GAP_CYCLES);
            ready_r     <= ~is_key;
            state_r     <= is_key ? ST_GAP : ST_IDLE;
          end
        end
        ST_GAP:
        begin
          gap_r <= gap_r - GAP_W'(1);
          if (gap_done)
          begin
            ready_r <= 1'b1;
            state_r <= ST_IDLE;
          end
        end
        default:
        begin
          req_r   <= 1'b0;
          ready_r <= 1'b0;
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  assign bus.req   = req_r;
  assign bus.we    = we_r;
  assign bus.addr  = addr_r;
  assign bus.wdata = wdata_r;
  assign cmd_ready = ready_r;
  assign rsp_valid = rsp_valid_r;
  assign rsp_rdata = rsp_rdata_r;

endmodule

// ===== bench/lwt_bus_sva.sv
module lwt_bus_sva
(
  input wire logic                       clock,
  input wire logic                       arst_n,
  input wire logic                       req,
  input wire logic                       we,
  input wire logic [lwt_pkg::ADDR_W-1:0] addr,
  input wire logic [lwt_pkg::DATA_W-1:0] wdata,
  input wire logic                       ack,
  input wire logic [lwt_pkg::DATA_W-1:0] rdata,
  input wire logic                       wdog_reset,
  input wire logic                       wdog_irq
);
  import lwt_pkg::*;

  // ----------------------------------------------------------------
  // shadow of what the device should hold
  // ----------------------------------------------------------------
  logic        lock_r;
  logic        dis_r;
  logic [15:0] ctrl_r;
  logic [15:0] load_r;
  wire         take    = req && !ack;
  wire         rd_take = take && !we;
  wire         good_key = take && we && addr == OFF_KEY && wdata == SERVICE_KEY;
  wire         bad_key = take && we && addr == OFF_KEY && wdata != SERVICE_KEY;
  // only one disable is ever honoured, and nothing after the lock
  wire         ctrl_ok = take && we && addr == OFF_CTRL && !lock_r && (wdata[CTRL_ENABLE] || !dis_r);
  wire         load_ok = take && we && addr == OFF_LOAD && !lock_r;

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lock_r <= 1'b0;
      dis_r  <= 1'b0;
      ctrl_r <= RST_CTRL;
      load_r <= RST_LOAD;
    end
    else
    begin
      if (ctrl_ok)
        ctrl_r <= (wdata & CTRL_KEEP_MASK) | CTRL_SET_MASK;
      if (ctrl_ok && wdata[CTRL_ENABLE])
        lock_r <= 1'b1;
      if (ctrl_ok && !wdata[CTRL_ENABLE])
        dis_r <= 1'b1;
      if (load_ok)
        load_r <= wdata;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_ack_next; take |=> ack; endproperty
  a_ack_next: assert property (p_ack_next) else $error("request not answered next cycle");
  property p_ack_pulse; ack |=> !ack; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_bad_key; bad_key |-> ##[1:3] (wdog_irq || wdog_reset); endproperty
  a_bad_key: assert property (p_bad_key) else $error("wrong key gave no timeout action");
  property p_good_key; good_key |-> ##1 !wdog_irq; endproperty
  a_good_key: assert property (p_good_key) else $error("valid key left irq pending");
  property p_irq_hold; $fell(wdog_irq) |-> $past(good_key); endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped without valid key");
  property p_rst_pulse; wdog_reset |=> !wdog_reset; endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("reset request not a single pulse");
  property p_ctrl_rd; rd_take && addr == OFF_CTRL |=> rdata == ctrl_r; endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("control readback wrong");
  property p_load_rd; rd_take && addr == OFF_LOAD |=> rdata == load_r; endproperty
  a_load_rd: assert property (p_load_rd) else $error("load readback wrong");
  property p_lock_rd; rd_take && addr == OFF_STATUS |=> rdata[STA_LOCK] == lock_r && rdata[5]; endproperty
  a_lock_rd: assert property (p_lock_rd) else $error("status lock bit wrong");
endmodule

// ===== bench/lockable_watchdog_timer_bench.sv
module lockable_watchdog_timer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import lwt_pkg::*;

  localparam realtime P = 30518.0;
  logic        clock;
  logic        arst_n;
  logic        low_freq_oscillator;
  logic        cpu_halted;
  logic        cmd_valid;
  logic        cmd_write;
  logic        cmd_ready;
  logic        rsp_valid;
  logic        wdog_reset;
  logic        wdog_irq;
  logic [7:0]  cmd_addr;
  logic [15:0] cmd_wdata;
  logic [15:0] rsp_rdata;
  logic [15:0] n_rst = 16'h0000;
  logic [15:0] n0;
  int          n_fail;
  int          check_count;
  int          cyc;
  realtime     t0;
  realtime     t1;

  lwt_bus_if bus_i ();
  lwt_device u_lwt_device (.bus(bus_i), .clock(clock), .arst_n(arst_n), .low_freq_oscillator(low_freq_oscillator),
    .cpu_halted(cpu_halted), .wdog_reset(wdog_reset), .wdog_irq(wdog_irq));
  // gap of four slow cycles between key writes
  lwt_host #(.GAP_CYCLES(KEY_GAP_CYC)) u_lwt_host (.bus(bus_i), .clock(clock), .arst_n(arst_n),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
  lwt_bus_sva u_lwt_bus_sva (.clock(clock), .arst_n(arst_n), .req(bus_i.req), .we(bus_i.we), .addr(bus_i.addr),
    .wdata(bus_i.wdata), .ack(bus_i.ack), .rdata(bus_i.rdata), .wdog_reset(wdog_reset), .wdog_irq(wdog_irq));

  // ----------------------------------------------------------------
  // clocks and watchdog of the run
  // ----------------------------------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  initial
  begin
    low_freq_oscillator = 1'b0;
    forever #15259 low_freq_oscillator = ~low_freq_oscillator;
  end
  always @(posedge clock)
  begin
    cyc++;
    if (wdog_reset === 1'b1)
      n_rst++;
    if (cyc == 40000)
    begin
      n_fail++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_t(input realtime got, input realtime lo, input realtime hi);
    check_count++;
    if (got < lo || got > hi)
    begin
      n_fail++;
      $display("BAD t=%0t delay %0t outside window", $time, got);
    end
  endtask

  // commands are offered just after an edge and held until taken
  task automatic cmd(input logic w, input logic [7:0] a, input logic [15:0] d, output logic [15:0] r);
    int n;
    n = 0;
    @(posedge clock);
    #1;
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_addr  = a;
    cmd_wdata = d;
    while (cmd_ready !== 1'b1 && n < 5000)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    @(posedge clock);
    #1;
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 20)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    r = rsp_rdata;
    if (rsp_valid !== 1'b1)
    begin
      n_fail++;
      $display("BAD t=%0t no response to command", $time);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] r;
    cmd(1'b1, a, d, r);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] r;
    cmd(1'b0, a, 16'h0000, r);
    chk(r, e);
  endtask

  // start on a slow falling edge so no tick lands mid-command
  task automatic at_fall();
    @(negedge low_freq_oscillator);
  endtask

  task automatic wait_irq(output realtime t);
    int n;
    n = 0;
    while (wdog_irq !== 1'b1 && n < 6000)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    t = $realtime;
  endtask

  task automatic do_reset();
    arst_n = 1'b0;
    repeat (2) @(posedge clock);
    #1;
    arst_n = 1'b1;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {cpu_halted, cmd_valid, cmd_write} = 3'h0;
    cmd_addr  = 8'h00;
    cmd_wdata = 16'h0000;
    do_reset();
    rd_chk(OFF_LOAD, RST_LOAD);
    rd_chk(OFF_COUNT, RST_COUNT);
    rd_chk(OFF_CTRL, RST_CTRL);
    rd_chk(OFF_STATUS, RST_STATUS);
    rd_chk(OFF_KEY, 16'h0000);
    rd_chk(8'h10, 16'h0000);
    // disable: periodic, divide by one, interrupt on timeout
    at_fall();
    wr(OFF_CTRL, 16'h00c2);
    rd_chk(OFF_STATUS, 16'h0028);
    rd_chk(OFF_COUNT, 16'h1000);
    wr(OFF_LOAD, 16'h0005);
    rd_chk(OFF_COUNT, 16'h0005);
    repeat (2000) @(posedge clock);
    rd_chk(OFF_COUNT, 16'h0005);
    wr(OFF_LOAD, 16'h0001);
    rd_chk(OFF_LOAD, 16'h0003);
    // enable and lock; halted cpu must not stop it with freeze off
    at_fall();
    t0 = $realtime;
    wr(OFF_CTRL, 16'h00e2);
    cpu_halted = 1'b1;
    wr(OFF_CTRL, 16'h00c2);
    rd_chk(OFF_CTRL, 16'h00e2);
    wr(OFF_LOAD, 16'h0009);
    rd_chk(OFF_LOAD, 16'h0003);
    wait_irq(t1);
    chk_t(t1 - t0, 3.0 * P, 4.0 * P);
    cpu_halted = 1'b0;
    repeat (1300) @(posedge clock);
    rd_chk(OFF_STATUS, 16'h0031);
    at_fall();
    t0 = $realtime;
    wr(OFF_KEY, SERVICE_KEY);
    chk({15'h0000, wdog_irq}, 16'h0000);
    wait_irq(t1);
    chk_t(t1 - t0, 3.0 * P, 4.0 * P);
    // second reset releases the lock; now fixed mode, reset action
    do_reset();
    rd_chk(OFF_CTRL, RST_CTRL);
    wr(OFF_CTRL, 16'h0080);
    at_fall();
    wr(OFF_CTRL, 16'h00a1);
    rd_chk(OFF_COUNT, FIXED_RELOAD);
    // freeze on while halted: count holds, then resumes from where it stood
    cpu_halted = 1'b1;
    repeat (2000) @(posedge clock);
    rd_chk(OFF_COUNT, FIXED_RELOAD);
    at_fall();
    @(posedge clock);
    #1;
    cpu_halted = 1'b0;
    at_fall();
    at_fall();
    rd_chk(OFF_COUNT, 16'h0ffe);
    n0 = n_rst;
    wr(OFF_KEY, 16'h1234);
    repeat (3) @(posedge clock);
    chk(n_rst - n0, 16'h0001);
    chk({15'h0000, wdog_irq}, 16'h0000);
    final_report();
  end
endmodule
